// file: design/mad_decoder.sv
// Register file, program memory and data memory address decoder
`timescale 1ns/100ps
module mad_decoder
    import mad_pkg::*;
#(
    parameter int RAM_BYTES = 1024,
    parameter int FLASH_BYTES = 8192,
    parameter logic [7:0] UNDEF_BYTE = UNDEF_BYTE_DEF,
    parameter logic [7:0] PAGE_SEL_OFS = PAGE_SEL_OFS_DEF,
    parameter int RAM_AW = $clog2(RAM_BYTES),
    parameter int FL_AW = $clog2(FLASH_BYTES)
) (
    input wire logic core_clk,
    input wire logic rstn,
    // Register file port from the core
    input wire logic rf_req,
    input wire mad_rf_cmd_t rf_cmd,
    output logic rf_rvalid,
    output logic [DW-1:0] rf_rdata,
    // Control register region toward the peripherals
    output logic ctl_req,
    output mad_ctl_cmd_t ctl_cmd,
    input wire logic [DW-1:0] ctl_rdata,
    input wire logic ctl_hit,
    // Program memory port from the core
    input wire logic pm_req,
    input wire mad_pm_cmd_t pm_cmd,
    output logic pm_rvalid,
    output logic [DW-1:0] pm_rdata,
    output mad_pm_region_t pm_region,
    // Flash array
    output logic fl_req,
    output logic fl_we,
    output logic [FL_AW-1:0] fl_addr,
    output logic [DW-1:0] fl_wdata,
    input wire logic [DW-1:0] fl_rdata,
    // Data memory port from the core
    input wire logic dm_req,
    input wire mad_pm_cmd_t dm_cmd,
    output logic dm_rvalid,
    output logic [DW-1:0] dm_rdata,
    // Factory load of the information area
    input wire logic info_ld_we,
    input wire logic [INFO_AW-1:0] info_ld_addr,
    input wire logic [DW-1:0] info_ld_data,
    output logic info_en
);

    localparam logic [RF_AW-1:0] RAM_TOP = RF_AW'(RAM_BYTES);
    localparam logic [PM_AW:0] FL_TOP = (PM_AW+1)'(FLASH_BYTES);

    // ----------------------------------------------------------------
    // Register file decode
    // ----------------------------------------------------------------
    logic rf_is_ctl;
    logic rf_is_ram;
    logic ram_we;
    logic ram_re;
    logic [DW-1:0] ram_rdata;

    assign rf_is_ctl = rf_cmd.addr >= RF_CTL_BASE;
    assign rf_is_ram = !rf_is_ctl && (rf_cmd.addr < RAM_TOP);
    // Gap addresses reach no storage at all
    assign ram_we = rf_req && rf_is_ram && rf_cmd.we;
    assign ram_re = rf_req && rf_is_ram && !rf_cmd.we;

    // Low byte of the address selects within the control region
    assign ctl_req = rf_req && rf_is_ctl;
    assign ctl_cmd = '{we: rf_cmd.we, addr: rf_cmd.addr[CTL_AW-1:0], wdata: rf_cmd.wdata};

    mad_mem #(
        .WIDTH(DW),
        .DEPTH(RAM_BYTES)
    ) u_ram (
        .core_clk(core_clk),
        .rstn(rstn),
        .we(ram_we),
        .waddr(rf_cmd.addr[RAM_AW-1:0]),
        .wdata(rf_cmd.wdata),
        .re(ram_re),
        .raddr(rf_cmd.addr[RAM_AW-1:0]),
        .rdata(ram_rdata)
    );

    // ----------------------------------------------------------------
    // Register file read pipeline
    // ----------------------------------------------------------------
    logic rf_rd_q;
    logic rf_src_ram_q;
    logic rf_src_ctl_q;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rf_rd_q <= 1'b0;
            rf_src_ram_q <= 1'b0;
            rf_src_ctl_q <= 1'b0;
        end else begin
            rf_rd_q <= rf_req && !rf_cmd.we;
            rf_src_ram_q <= rf_is_ram;
            rf_src_ctl_q <= rf_is_ctl;
        end
    end

    // Strobe kept apart from the data select so it never waits on it
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rf_rvalid <= 1'b0;
        end else begin
            rf_rvalid <= rf_rd_q;
        end
    end

    // Gap and reserved reads fall through to the fill byte
    logic [DW-1:0] rf_rdata_d;

    always_comb begin
        rf_rdata_d = UNDEF_BYTE;
        if (rf_src_ram_q) begin
            rf_rdata_d = ram_rdata;
        end else if (rf_src_ctl_q && ctl_hit) begin
            rf_rdata_d = ctl_rdata;
        end else if (rf_src_ctl_q) begin
            rf_rdata_d = UNDEF_BYTE;
        end
    end

    // Data holds until the next answer, so a slow reader still sees it
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rf_rdata <= '0;
        end else if (rf_rd_q) begin
            rf_rdata <= rf_rdata_d;
        end
    end

    // ----------------------------------------------------------------
    // Flash page select copy
    // ----------------------------------------------------------------
    // Writes still reach the peripheral; this copy only steers the overlay
    logic [DW-1:0] page_sel_q;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            page_sel_q <= PAGE_SEL_RESET;
        end else if (ctl_req && rf_cmd.we && rf_cmd.addr[CTL_AW-1:0] == PAGE_SEL_OFS) begin
            page_sel_q <= rf_cmd.wdata;
        end
    end

    assign info_en = page_sel_q[PAGE_SEL_INFO_BIT];

    // ----------------------------------------------------------------
    // Program memory decode
    // ----------------------------------------------------------------
    function automatic mad_pm_region_t pm_classify(input logic [PM_AW-1:0] a,
                                                   input logic ovl);
        mad_pm_region_t r;
        r = MAD_PM_UNIMPL;
        if (ovl && a >= PM_INFO_LO && a <= PM_INFO_HI) begin
            r = MAD_PM_INFO;
        end else if ({1'b0, a} >= FL_TOP) begin
            r = MAD_PM_UNIMPL;
        end else if (a >= PM_CODE_LO) begin
            r = MAD_PM_CODE;
        end else if (a >= PM_OSC_TRAP_LO) begin
            r = MAD_PM_OSC_TRAP;
        end else if (a >= PM_IRQ_VEC_LO) begin
            r = MAD_PM_IRQ;
        end else if (a >= PM_TRAP_LO) begin
            r = MAD_PM_TRAP;
        end else if (a >= PM_WDOG_VEC_LO) begin
            r = MAD_PM_WDOG;
        end else if (a >= PM_RST_VEC_LO) begin
            r = MAD_PM_RESET;
        end else begin
            r = MAD_PM_OPTION;
        end
        return r;
    endfunction

    mad_pm_region_t pm_reg_d;
    logic pm_in_flash;
    logic pm_info_data;
    logic [DW-1:0] info_rdata;

    assign pm_reg_d = pm_classify(pm_cmd.addr, info_en);
    assign pm_in_flash = pm_reg_d != MAD_PM_INFO && pm_reg_d != MAD_PM_UNIMPL;
    // Only FE00h-FE7Fh holds stored bytes; the rest of the window is reserved
    assign pm_info_data = pm_reg_d == MAD_PM_INFO && pm_cmd.addr < PM_INFO_RSVD_LO;

    assign fl_req = pm_req && pm_in_flash;
    assign fl_we = pm_req && pm_in_flash && pm_cmd.we;
    assign fl_addr = pm_cmd.addr[FL_AW-1:0];
    assign fl_wdata = pm_cmd.wdata;

    // Loaded once by the factory path; the core's port never writes it
    mad_mem #(
        .WIDTH(DW),
        .DEPTH(INFO_BYTES)
    ) u_info (
        .core_clk(core_clk),
        .rstn(rstn),
        .we(info_ld_we),
        .waddr(info_ld_addr),
        .wdata(info_ld_data),
        .re(pm_req && pm_info_data && !pm_cmd.we),
        .raddr(pm_cmd.addr[INFO_AW-1:0]),
        .rdata(info_rdata)
    );

    // ----------------------------------------------------------------
    // Program memory read pipeline
    // ----------------------------------------------------------------
    logic pm_rd_q;
    logic pm_info_q;
    mad_pm_region_t pm_reg_q;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pm_rd_q <= 1'b0;
            pm_info_q <= 1'b0;
            pm_reg_q <= MAD_PM_UNIMPL;
        end else begin
            pm_rd_q <= pm_req && !pm_cmd.we;
            pm_info_q <= pm_info_data;
            if (pm_req) begin
                pm_reg_q <= pm_reg_d;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pm_rvalid <= 1'b0;
        end else begin
            pm_rvalid <= pm_rd_q;
        end
    end

    // Region travels with the byte it explains
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pm_region <= MAD_PM_UNIMPL;
        end else if (pm_rd_q) begin
            pm_region <= pm_reg_q;
        end
    end

    // Case sits under the strobe so an idle, unknown region is never decoded
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pm_rdata <= '0;
        end else if (pm_rd_q) begin
            unique case (pm_reg_q)
                MAD_PM_INFO: begin
                    pm_rdata <= pm_info_q ? info_rdata : UNDEF_BYTE;
                end
                MAD_PM_UNIMPL: begin
                    pm_rdata <= PM_UNIMPL_BYTE;
                end
                MAD_PM_OPTION, MAD_PM_RESET, MAD_PM_WDOG, MAD_PM_TRAP,
                MAD_PM_IRQ, MAD_PM_OSC_TRAP, MAD_PM_CODE: begin
                    pm_rdata <= fl_rdata;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Data memory space
    // ----------------------------------------------------------------
    // Nothing is stored here; reads complete so the core never hangs
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            dm_rvalid <= 1'b0;
        end else begin
            dm_rvalid <= dm_req && !dm_cmd.we;
        end
    end

    // Constant fill, so no data space access can leak a stored byte
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            dm_rdata <= '0;
        end else begin
            dm_rdata <= UNDEF_BYTE;
        end
    end

endmodule

// file: design/mad_mem.sv
// Small byte memory with one write port and a registered read port
`timescale 1ns/100ps
module mad_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 256,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic re,
    input wire logic [AW-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);

    logic [WIDTH-1:0] mem_q [DEPTH];

    // Storage holds no reset; contents are undefined until written
    always_ff @(posedge core_clk) begin
        if (we) begin
            mem_q[waddr] <= wdata;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= '0;
        end else if (re) begin
            rdata <= mem_q[raddr];
        end
    end

endmodule

// file: shared/mad_pkg.sv
// Constants and carrier types of the MCU address space decoder
package mad_pkg;

    // ----------------------------------------------------------------
    // Widths and space sizes
    // ----------------------------------------------------------------
    localparam int RF_AW = 12;
    localparam int PM_AW = 16;
    localparam int DW = 8;
    localparam int RF_BYTES = 4096;
    localparam int PM_BYTES = 65536;
    localparam int CTL_AW = 8;
    localparam int INFO_BYTES = 128;
    localparam int INFO_AW = 7;

    // ----------------------------------------------------------------
    // Register file map
    // ----------------------------------------------------------------
    localparam logic [11:0] RF_RAM_BASE = 12'h000;
    localparam logic [11:0] RF_CTL_BASE = 12'hF00;
    localparam logic [11:0] RF_CTL_LAST = 12'hFFF;

    // ----------------------------------------------------------------
    // Program memory map
    // ----------------------------------------------------------------
    localparam logic [15:0] PM_OPT_LO = 16'h0000;
    localparam logic [15:0] PM_RST_VEC_LO = 16'h0002;
    localparam logic [15:0] PM_WDOG_VEC_LO = 16'h0004;
    localparam logic [15:0] PM_TRAP_LO = 16'h0006;
    localparam logic [15:0] PM_IRQ_VEC_LO = 16'h0008;
    localparam logic [15:0] PM_OSC_TRAP_LO = 16'h0038;
    localparam logic [15:0] PM_CODE_LO = 16'h003E;
    localparam logic [15:0] PM_INFO_LO = 16'hFE00;
    localparam logic [15:0] PM_INFO_RSVD_LO = 16'hFE80;
    localparam logic [15:0] PM_INFO_HI = 16'hFF7F;

    // ----------------------------------------------------------------
    // Fill values and the information area enable
    // ----------------------------------------------------------------
    localparam logic [7:0] PM_UNIMPL_BYTE = 8'hFF;
    localparam logic [7:0] UNDEF_BYTE_DEF = 8'h00;
    localparam logic [7:0] PAGE_SEL_RESET = 8'h00;
    localparam int PAGE_SEL_INFO_BIT = 7;
    localparam logic [7:0] PAGE_SEL_OFS_DEF = 8'hF8;

    // ----------------------------------------------------------------
    // Program memory region of the address last read
    // ----------------------------------------------------------------
    typedef enum logic [8:0] {
        MAD_PM_OPTION   = 9'b000000001,
        MAD_PM_RESET    = 9'b000000010,
        MAD_PM_WDOG     = 9'b000000100,
        MAD_PM_TRAP     = 9'b000001000,
        MAD_PM_IRQ      = 9'b000010000,
        MAD_PM_OSC_TRAP = 9'b000100000,
        MAD_PM_CODE     = 9'b001000000,
        MAD_PM_INFO     = 9'b010000000,
        MAD_PM_UNIMPL   = 9'b100000000
    } mad_pm_region_t;

    // ----------------------------------------------------------------
    // Request carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic we;
        logic [RF_AW-1:0] addr;
        logic [DW-1:0] wdata;
    } mad_rf_cmd_t;

    typedef struct packed {
        logic we;
        logic [PM_AW-1:0] addr;
        logic [DW-1:0] wdata;
    } mad_pm_cmd_t;

    typedef struct packed {
        logic we;
        logic [CTL_AW-1:0] addr;
        logic [DW-1:0] wdata;
    } mad_ctl_cmd_t;

endpackage

// file: test/mad_checker.sv
// Concurrent checks on the address space decoder ports
`timescale 1ns/100ps
module mad_checker
    import mad_pkg::*;
#(
    parameter int RAM_BYTES = 1024,
    parameter int FLASH_BYTES = 8192,
    parameter logic [7:0] UNDEF_BYTE = 8'h00,
    parameter int FL_AW = 13
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic rf_req,
    input wire mad_rf_cmd_t rf_cmd,
    input wire logic rf_rvalid,
    input wire logic [DW-1:0] rf_rdata,
    input wire logic ctl_req,
    input wire mad_ctl_cmd_t ctl_cmd,
    input wire logic ctl_hit,
    input wire logic pm_req,
    input wire mad_pm_cmd_t pm_cmd,
    input wire logic pm_rvalid,
    input wire logic [DW-1:0] pm_rdata,
    input wire mad_pm_region_t pm_region,
    input wire logic fl_we,
    input wire logic fl_req,
    input wire logic [FL_AW-1:0] fl_addr,
    input wire logic [DW-1:0] fl_wdata,
    input wire logic dm_req,
    input wire mad_pm_cmd_t dm_cmd,
    input wire logic dm_rvalid,
    input wire logic [DW-1:0] dm_rdata,
    input wire logic info_en
);
    // ------
    // Request shapes
    // ------
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rstn);
    logic ovl;
    assign ovl = info_en && pm_cmd.addr >= 16'hFE00 && pm_cmd.addr <= 16'hFF7F;
    sequence rf_rd_s;
        rf_req && !rf_cmd.we;
    endsequence
    sequence ctl_rd_s;
        rf_rd_s ##0 rf_cmd.addr >= 12'hF00;
    endsequence
    sequence pm_rd_s;
        pm_req && !pm_cmd.we;
    endsequence
    ctl_route_a: assert property (rf_req && rf_cmd.addr >= 12'hF00 |->
        ctl_req && ctl_cmd.addr == rf_cmd.addr[7:0] && ctl_cmd.we == rf_cmd.we &&
        ctl_cmd.wdata == rf_cmd.wdata)
        else $error("control access not forwarded");
    ram_local_a: assert property (rf_req && rf_cmd.addr < 12'hF00 |-> !ctl_req)
        else $error("ram access leaked to control region");
    rf_answer_a: assert property (rf_rd_s |-> ##2 rf_rvalid)
        else $error("register file read not answered");
    gap_undef_a: assert property (rf_rd_s ##0
        (rf_cmd.addr >= RAM_BYTES && rf_cmd.addr < 12'hF00) |-> ##2 rf_rdata == UNDEF_BYTE)
        else $error("gap read not undefined byte");
    ctl_rsvd_a: assert property (ctl_rd_s ##1 !ctl_hit |-> ##1 rf_rdata == UNDEF_BYTE)
        else $error("reserved control read not undefined byte");
    pm_blank_a: assert property (pm_rd_s ##0 (pm_cmd.addr >= FLASH_BYTES && !ovl) |->
        ##2 pm_rvalid && pm_rdata == 8'hFF)
        else $error("unimplemented program read not FF");
    fl_guard_a: assert property (fl_we |->
        pm_req && pm_cmd.we && pm_cmd.addr < FLASH_BYTES && !ovl)
        else $error("flash write outside allowed range");
    dm_none_a: assert property (dm_req && !dm_cmd.we |=> dm_rvalid && dm_rdata == UNDEF_BYTE)
        else $error("data space read returned storage");
    info_en_a: assert property (rf_req && rf_cmd.we && rf_cmd.addr == 12'hFF8 |=>
        info_en == $past(rf_cmd.wdata[7]))
        else $error("info enable did not follow page select");
    rst_vec_a: assert property (pm_rd_s ##0 pm_cmd.addr[15:1] == 15'h0001 |->
        ##2 pm_region == MAD_PM_RESET)
        else $error("reset vector region wrong");
    info_rsvd_a: assert property (pm_rd_s ##0 (ovl && pm_cmd.addr >= 16'hFE80) |->
        ##2 pm_rdata == UNDEF_BYTE)
        else $error("reserved info read not undefined byte");
    fl_write_a: assert property (pm_req && pm_cmd.we && !ovl &&
        pm_cmd.addr < FLASH_BYTES |-> fl_we && fl_wdata == pm_cmd.wdata)
        else $error("legal flash write not forwarded");
    fl_addr_a: assert property (pm_rd_s ##0 (pm_cmd.addr < FLASH_BYTES && !ovl) |->
        fl_req && fl_addr == pm_cmd.addr[FL_AW-1:0])
        else $error("flash read address not forwarded");
endmodule

// file: test/mad_far_side.sv
// Far-side model: peripheral register answers and flash array data
`timescale 1ns/100ps
module mad_far_side
    import mad_pkg::*;
#(
    parameter int FL_AW = 12
) (
    input wire logic core_clk,
    input wire logic ctl_req,
    input wire mad_ctl_cmd_t ctl_cmd,
    output logic [DW-1:0] ctl_rdata,
    output logic ctl_hit,
    input wire logic fl_req,
    input wire logic [FL_AW-1:0] fl_addr,
    output logic [DW-1:0] fl_rdata
);
    initial begin
        ctl_rdata = 8'h00;
        ctl_hit = 1'b0;
        fl_rdata = 8'h00;
    end
    // Answers hold one cycle only; otherwise lines scramble
    always @(posedge core_clk) begin
        if (ctl_req && !ctl_cmd.we) begin
            ctl_hit <= ctl_cmd.addr < 8'h10;
            ctl_rdata <= ctl_cmd.addr ^ 8'h5A;
        end else begin
            ctl_hit <= ~ctl_hit;
            ctl_rdata <= ~ctl_rdata;
        end
        if (fl_req) fl_rdata <= fl_addr[7:0] ^ 8'hC3;
        else fl_rdata <= ~fl_rdata;
    end
endmodule

// file: test/test_mad_decoder.sv
// Self-checking bench for the address space decoder
`timescale 1ns/100ps
module test_mad_decoder;
    import mad_pkg::*;
    localparam int RAMB = 512;
    localparam int FLB = 4096;
    localparam logic [15:0] VA [13] = '{16'h0, 16'h1, 16'h2, 16'h3, 16'h5, 16'h6, 16'h8,
        16'h37, 16'h38, 16'h3D, 16'h3E, 16'hFFF, 16'h1000};
    localparam logic [8:0] VR [13] = '{9'h1, 9'h1, 9'h2, 9'h2, 9'h4, 9'h8, 9'h10, 9'h10,
        9'h20, 9'h20, 9'h40, 9'h40, 9'h100};
    localparam logic [11:0] CA [5] = '{12'hF00, 12'hF0F, 12'hF10, 12'hF80, 12'hFFF};
    localparam logic [6:0] IA [5] = '{7'h00, 7'h40, 7'h53, 7'h60, 7'h7F};
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic rf_req = 1'b0, pm_req = 1'b0, dm_req = 1'b0, info_ld_we = 1'b0;
    mad_rf_cmd_t rf_cmd = '0;
    mad_pm_cmd_t pm_cmd = '0, dm_cmd = '0;
    logic [6:0] info_ld_addr = '0;
    logic [7:0] info_ld_data = '0;
    logic rf_rvalid, pm_rvalid, dm_rvalid, ctl_req, ctl_hit, fl_req, fl_we, info_en;
    logic [7:0] rf_rdata, pm_rdata, dm_rdata, ctl_rdata, fl_rdata, fl_wdata;
    logic [11:0] fl_addr;
    mad_ctl_cmd_t ctl_cmd;
    mad_pm_region_t pm_region;
    int error_cnt = 0, check_count = 0, seed = 25;
    logic [7:0] rf_q[$], dm_q[$];
    logic [17:0] pm_q[$];
    logic [17:0] e;
    always #2 core_clk = ~core_clk;
    mad_decoder #(.RAM_BYTES(RAMB), .FLASH_BYTES(FLB)) DUT (.core_clk, .rstn, .rf_req,
        .rf_cmd, .rf_rvalid, .rf_rdata, .ctl_req, .ctl_cmd, .ctl_rdata, .ctl_hit, .pm_req,
        .pm_cmd, .pm_rvalid, .pm_rdata, .pm_region, .fl_req, .fl_we, .fl_addr, .fl_wdata,
        .fl_rdata, .dm_req, .dm_cmd, .dm_rvalid, .dm_rdata, .info_ld_we, .info_ld_addr,
        .info_ld_data, .info_en);
    mad_far_side #(.FL_AW(12)) u_far (.core_clk, .ctl_req, .ctl_cmd, .ctl_rdata, .ctl_hit,
        .fl_req, .fl_addr, .fl_rdata);
    // ------
    // Checking and closing
    // ------
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        if (error_cnt == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // k: 0 register file, 1 program, 2 data, 3 idle; on reads d is the expected byte
    task automatic op(input int k, input logic we, input logic [15:0] a,
            input logic [7:0] d, input logic [9:0] r = 10'h000);
        @(posedge core_clk);
        rf_req <= k == 0;
        pm_req <= k == 1;
        dm_req <= k == 2;
        info_ld_we <= 1'b0;
        rf_cmd <= '{we, a[11:0], d};
        pm_cmd <= '{we, a, d};
        dm_cmd <= '{we, a, d};
        if (!we && k == 0) rf_q.push_back(d);
        if (!we && k == 1) pm_q.push_back({r, d});
        if (!we && k == 2) dm_q.push_back(d);
    endtask
    always @(posedge core_clk) begin
        if (rf_rvalid === 1'b1) chk(rf_rdata, rf_q.size() ? rf_q.pop_front() : 8'hxx);
        if (dm_rvalid === 1'b1) chk(dm_rdata, dm_q.size() ? dm_q.pop_front() : 8'hxx);
        if (pm_rvalid === 1'b1) begin
            e = pm_q.size() ? pm_q.pop_front() : 18'hxxxxx;
            chk({e[17], e[17] ? pm_region : e[16:8], pm_rdata}, e);
        end
    end
    initial begin
        #40000;
        error_cnt++;
        complete_run;
    end
    // ------
    // Stimulus
    // ------
    initial begin
        logic [7:0] d0, d1;
        logic [7:0] v [5];
        repeat (6) @(posedge core_clk);
        chk({rf_rvalid, pm_rvalid, dm_rvalid, info_en, pm_region}, 18'h00100);
        rstn <= 1'b1;
        d0 = 8'($random(seed));
        d1 = 8'($random(seed));
        op(0, 1, 0, d0);
        op(0, 1, RAMB - 1, d1);
        op(0, 1, RAMB, ~d0);
        op(0, 1, 16'hEFF, ~d1);
        op(0, 0, 0, d0);
        op(0, 0, RAMB - 1, d1);
        op(0, 0, RAMB, 8'h00);
        op(0, 0, 16'hEFF, 8'h00);
        op(0, 1, 16'hF00, 8'h12);
        for (int i = 0; i < 5; i++)
            op(0, 0, CA[i], CA[i][7:0] < 8'h10 ? CA[i][7:0] ^ 8'h5A : 8'h00);
        for (int i = 0; i < 13; i++)
            op(1, 0, VA[i], VA[i] < FLB ? VA[i][7:0] ^ 8'hC3 : 8'hFF, {1'b1, VR[i]});
        op(1, 1, 16'h0100, d0);
        op(1, 1, 16'h2000, d1);
        op(1, 0, 16'h2000, 8'hFF);
        op(2, 0, 16'h1234, 8'h00);
        op(2, 1, 16'h0000, d0);
        op(1, 0, 16'hFE00, 8'hFF, 10'h300);
        op(3, 0, 0, 0);
        for (int i = 0; i < 5; i++) begin
            @(posedge core_clk);
            v[i] = 8'($random(seed));
            info_ld_we <= 1'b1;
            info_ld_addr <= IA[i];
            info_ld_data <= v[i];
        end
        op(0, 1, 16'hFF8, 8'h80);
        op(3, 0, 0, 0);
        @(posedge core_clk);
        #1 chk(info_en, 1'b1);
        for (int i = 0; i < 5; i++)
            op(1, 0, 16'hFE00 + IA[i], v[i], 10'h280);
        op(1, 0, 16'hFE80, 8'h00);
        op(1, 0, 16'hFF7F, 8'h00);
        op(1, 0, 16'hFF80, 8'hFF, 10'h300);
        op(1, 1, 16'hFE00, ~v[0]);
        op(1, 0, 16'hFE00, v[0]);
        op(0, 1, 16'hFF8, 8'h00);
        op(3, 0, 0, 0);
        op(1, 0, 16'hFE40, 8'hFF, 10'h300);
        op(3, 0, 0, 0);
        repeat (4) @(posedge core_clk);
        chk(rf_q.size() + pm_q.size() + dm_q.size(), 0);
        complete_run;
    end
endmodule
bind mad_decoder mad_checker #(.RAM_BYTES(RAM_BYTES), .FLASH_BYTES(FLASH_BYTES),
    .UNDEF_BYTE(UNDEF_BYTE), .FL_AW(FL_AW)) u_chk (.core_clk, .rstn, .rf_req, .rf_cmd,
    .rf_rvalid, .rf_rdata, .ctl_req, .ctl_cmd, .ctl_hit, .pm_req, .pm_cmd, .pm_rvalid,
    .pm_rdata, .pm_region, .fl_we, .fl_req, .fl_addr, .fl_wdata, .dm_req, .dm_cmd,
    .dm_rvalid, .dm_rdata, .info_en);
